// ==== src/bcp_map.vh ====
`ifndef BCP_MAP_VH
`define BCP_MAP_VH
// ==========================================================
// register byte addresses
`define BCP_BLOCK_BASE 32'hFFFF0F80
`define BCP_ADR_CTRL 32'hFFFF0F80
`define BCP_ADR_P0_RISE 32'hFFFF0F84
`define BCP_ADR_P0_FALL 32'hFFFF0F88
`define BCP_ADR_P0_THIRD 32'hFFFF0F8C
`define BCP_ADR_P0_LEN 32'hFFFF0F90
`define BCP_ADR_P1_RISE 32'hFFFF0F94
`define BCP_ADR_P1_FALL 32'hFFFF0F98
`define BCP_ADR_P1_THIRD 32'hFFFF0F9C
`define BCP_ADR_P1_LEN 32'hFFFF0FA0
`define BCP_ADR_P2_RISE 32'hFFFF0FA4
`define BCP_ADR_P2_FALL 32'hFFFF0FA8
`define BCP_ADR_P2_LEN 32'hFFFF0FB0
`define BCP_ADR_STATUS 32'hFFFF0FB4
`define BCP_ADR_TRIP_CLR 32'hFFFF0FB8
// compare slot that has no register behind it
`define BCP_SLOT_HOLE 4'hA
`define BCP_SLOT_COUNT 12
// ==========================================================
// control register reset value and fields
`define BCP_CTRL_RESET 16'h0012
`define BCP_CTRL_MASTER_EN 0
`define BCP_CTRL_BRIDGE 1
`define BCP_CTRL_PHASE_SIDE 2
`define BCP_CTRL_LOAD_REQ 3
`define BCP_CTRL_HS_OFF 4
`define BCP_CTRL_POL_INV 5
`define BCP_CTRL_DIV_LO 6
`define BCP_CTRL_DIV_HI 8
`define BCP_CTRL_BR_OUT_EN 9
`define BCP_CTRL_TRIP_EN 10
`define BCP_CTRL_INV1 11
`define BCP_CTRL_INV3 12
`define BCP_CTRL_SYNC_EN 14
// writable control bits, reserved bit 13 and bit 15 read zero
`define BCP_CTRL_WMASK 16'h5FFF
// ==========================================================
// status register fields
`define BCP_STAT_IRQ 0
`define BCP_STAT_TRIP_PIN 1
`define BCP_STAT_SYNC_PIN 2
// prescaler base count, divide is this shifted by the code
`define BCP_DIV_BASE 9'h002
`endif

// ==== src/bcp_sync.v ====
`timescale 1ns/100ps
// ==========================================================
// two-stage synchroniser for pin inputs
module bcp_sync #(
  parameter W = 2,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input wire i_clk,
  input wire i_reset,
  input wire [W-1:0] i_d,
  output reg [W-1:0] o_q
);
  reg [W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta <= INIT;
      o_q <= INIT;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule // bcp_sync

// ==== src/bcp_pair.v ====
`timescale 1ns/100ps
// ==========================================================
// one timer pair: counter, shadow compares, two raw outputs
module bcp_pair #(
  parameter W = 16
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_run,
  input wire i_tick,
  input wire i_restart,
  input wire i_load_req,
  input wire [W-1:0] i_rise,
  input wire [W-1:0] i_fall,
  input wire [W-1:0] i_third,
  input wire [W-1:0] i_len,
  output reg [W-1:0] o_count,
  output reg o_a,
  output reg o_b
);
  reg [W-1:0] rise_q;
  reg [W-1:0] fall_q;
  reg [W-1:0] third_q;
  reg [W-1:0] len_q;
  reg [W-1:0] next_count;
  wire first_step;

  // wrap after the loaded length
  always @* begin
    if (o_count >= len_q)
      next_count = {W{1'b0}};
    else
      next_count = o_count + {{(W-1){1'b0}}, 1'b1};
  end

  // load on any tick at zero, so a zero length still picks up new compares
  assign first_step = i_tick && (o_count == {W{1'b0}});

  // shadow compares load on a tick at zero while the load request is set
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rise_q <= {W{1'b0}};
      fall_q <= {W{1'b0}};
      third_q <= {W{1'b0}};
      len_q <= {W{1'b0}};
    end else if (first_step && i_load_req) begin
      rise_q <= i_rise;
      fall_q <= i_fall;
      third_q <= i_third;
      len_q <= i_len;
    end
  end

  // counter and compare outputs, a clear wins a tie
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_count <= {W{1'b0}};
      o_a <= 1'b0;
      o_b <= 1'b0;
    end else if (!i_run || i_restart) begin
      o_count <= {W{1'b0}};
      o_a <= 1'b0;
      o_b <= 1'b0;
    end else if (i_tick) begin
      o_count <= next_count;
      if (next_count == fall_q)
        o_a <= 1'b0;
      else if (next_count == rise_q)
        o_a <= 1'b1;
      if (next_count == third_q)
        o_b <= 1'b0;
      else if (next_count == len_q)
        o_b <= 1'b1;
    end
  end
endmodule // bcp_pair

// ==== src/bcp_pwm.v ====
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/100ps
`include "bcp_map.vh"

module bcp_pwm #(
  parameter CW = 16
) (
  input wire I_CLK,
  input wire I_RESET,
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [31:0] I_WB_ADR,
  input wire [3:0] I_WB_SEL,
  input wire [31:0] I_WB_DAT,
  output reg [31:0] O_WB_DAT,
  output reg O_WB_ACK,
  input wire I_TRIP_N,
  input wire I_SYNC_N,
  output reg [4:0] O_WAVE,
  output reg [4:0] O_PIN_PWM_SEL,
  output wire O_IRQ
);
  // ==========================================================
  // declarations
  reg [15:0] ctrl;
  reg [CW-1:0] swreg [0:`BCP_SLOT_COUNT-1];
  reg irq_pending;
  reg sync_prev;
  reg sync_restart;
  reg [8:0] pre_cnt;
  reg pre_tick;
  reg [15:0] next_ctrl;
  reg [31:0] next_rdata;
  reg [4:0] next_wave;
  wire [1:0] pins_q;
  wire trip_low;
  wire sync_q;
  wire req;
  wire wr;
  wire in_block;
  wire [3:0] slot;
  wire slot_ok;
  wire [15:0] wmask;
  wire [8:0] pre_limit;
  wire [2:0] div_sel;
  wire [2:0] raw_a;
  wire [2:0] raw_b;
  wire hs;
  wire ls;
  wire run;

  // ==========================================================
  // control bit layout
  //   bit 0      waveform master enable, cleared by a trip while bit 10 is set
  //   bit 1      bridge mode select
  //   bit 2      phase side select
  //   bit 3      compare load request
  //   bit 4      high side off force
  //   bit 5      output polarity invert
  //   bits 8:6   clock divider select
  //   bit 9      bridge output enable
  //   bit 10     trip interrupt enable
  //   bit 11     invert out1 in standard mode
  //   bit 12     invert out3 in standard mode
  //   bit 13     reserved, reads zero
  //   bit 14     sync pin enable
  //   bit 15     reserved, reads zero

  // ==========================================================
  // address map, low byte of the word address
  //   0x80  pwm control
  //   0x84  pair0 rise compare
  //   0x88  pair0 fall compare
  //   0x8C  pair0 second fall compare
  //   0x90  pair0 length
  //   0x94  pair1 rise compare
  //   0x98  pair1 fall compare
  //   0x9C  pair1 second fall compare
  //   0xA0  pair1 length
  //   0xA4  pair2 rise compare
  //   0xA8  pair2 fall compare
  //   0xAC  no register, acked, reads zero
  //   0xB0  pair2 length
  //   0xB4  status: irq pending, synced trip, synced sync
  //   0xB8  trip interrupt clear, write only, reads zero

  // ==========================================================
  // timing notes
  //   bus: a request is taken on the edge with cyc and stb high and ack low;
  //     ack stands one cycle, so a request held past ack is taken again on the edge after the ack cycle
  //   pins: trip and sync pass two flip-flops, three to four cycles in all
  //     before they act on control, interrupt or the timers
  //   waveforms: a tick every 2 to 256 clocks steps all three timers;
  //     an output pin level changes two clocks after the matching tick
  //   a trip that meets a clear write in one cycle keeps the interrupt set

  // ==========================================================
  // limitations
  //   only byte lanes 0 and 1 are used; registers are 16 bits wide
  //   the bridge table overrides the master enable, so a stopped unit
  //     still shows its idle bridge pattern on out0 to out3
  //   compares are only used once a load request meets a tick at zero;
  //     shadows reset to zero, so the raw pair outputs stay low until the first load

  // ==========================================================
  // pin inputs through two flip-flops
  bcp_sync #(
    .W(2),
    .INIT(2'h3)
  ) u_pins (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_d({I_SYNC_N, I_TRIP_N}),
    .o_q(pins_q)
  );

  assign trip_low = ~pins_q[0];
  assign sync_q = pins_q[1];

  // ==========================================================
  // bus decode
  assign req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  assign wr = req && I_WB_WE;
  assign in_block = ({I_WB_ADR[31:6], 6'h00} == `BCP_BLOCK_BASE) && (I_WB_ADR[1:0] == 2'h0);
  // compare slots run from the first rise register upward
  assign slot = I_WB_ADR[5:2] - 4'h1;
  assign slot_ok = in_block && (I_WB_ADR[5:2] != 4'h0) && (slot < 4'hC)
    && (slot != `BCP_SLOT_HOLE);
  // byte enables on the low two lanes
  assign wmask = {{8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};

  // single-cycle acknowledge, also for unmapped addresses
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET)
      O_WB_ACK <= 1'b0;
    else
      O_WB_ACK <= req;
  end

  // ==========================================================
  // compare and length storage
  genvar k;
  generate
    for (k = 0; k < `BCP_SLOT_COUNT; k = k + 1) begin : g_slot
      always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET)
          swreg[k] <= {CW{1'b0}};
        else if (wr && slot_ok && (slot == k))
          swreg[k] <= (swreg[k] & ~wmask[CW-1:0]) | (I_WB_DAT[CW-1:0] & wmask[CW-1:0]);
      end
    end
  endgenerate

  // ==========================================================
  // control register
  always @* begin
    next_ctrl = ctrl;
    if (wr && in_block && (I_WB_ADR == `BCP_ADR_CTRL))
      next_ctrl = (ctrl & ~wmask) | (I_WB_DAT[15:0] & wmask);
    next_ctrl = next_ctrl & `BCP_CTRL_WMASK;
    if (ctrl[`BCP_CTRL_TRIP_EN] && trip_low)
      next_ctrl[`BCP_CTRL_MASTER_EN] = 1'b0;
  end

  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET)
      ctrl <= `BCP_CTRL_RESET;
    else
      ctrl <= next_ctrl;
  end

  // ==========================================================
  // trip interrupt, a new trip beats the clear
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET)
      irq_pending <= 1'b0;
    else if (ctrl[`BCP_CTRL_TRIP_EN] && trip_low)
      irq_pending <= 1'b1;
    else if (wr && in_block && (I_WB_ADR == `BCP_ADR_TRIP_CLR))
      irq_pending <= 1'b0;
  end

  assign O_IRQ = irq_pending;

  // ==========================================================
  // read data
  always @* begin
    next_rdata = 32'h00000000;
    if (slot_ok)
      next_rdata[CW-1:0] = swreg[slot];
    else if (in_block && (I_WB_ADR == `BCP_ADR_CTRL))
      next_rdata[15:0] = ctrl;
    else if (in_block && (I_WB_ADR == `BCP_ADR_STATUS)) begin
      next_rdata[`BCP_STAT_IRQ] = irq_pending;
      next_rdata[`BCP_STAT_TRIP_PIN] = pins_q[0];
      next_rdata[`BCP_STAT_SYNC_PIN] = sync_q;
    end
  end

  // read data held in a register for the ack cycle
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET)
      O_WB_DAT <= 32'h00000000;
    else if (req && !I_WB_WE)
      O_WB_DAT <= next_rdata;
  end

  // ==========================================================
  // prescaler
  assign div_sel = ctrl[`BCP_CTRL_DIV_HI:`BCP_CTRL_DIV_LO];
  // divide by 2 shifted by code
  assign pre_limit = (`BCP_DIV_BASE << div_sel) - 9'h001;
  assign run = ctrl[`BCP_CTRL_MASTER_EN];

  // one tick per divided period
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      pre_cnt <= 9'h000;
      pre_tick <= 1'b0;
    end else if (!run || sync_restart) begin
      pre_cnt <= 9'h000;
      pre_tick <= 1'b0;
    end else if (pre_cnt >= pre_limit) begin
      pre_cnt <= 9'h000;
      pre_tick <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 9'h001;
      pre_tick <= 1'b0;
    end
  end

  // ==========================================================
  // sync pin falling edge
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      sync_prev <= 1'b1;
      sync_restart <= 1'b0;
    end else begin
      sync_prev <= sync_q;
      sync_restart <= ctrl[`BCP_CTRL_SYNC_EN] && sync_prev && !sync_q;
    end
  end

  // ==========================================================
  // three timer pairs
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_pair
      bcp_pair #(
        .W(CW)
      ) u_pair (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .i_run(run),
        .i_tick(pre_tick),
        .i_restart(sync_restart),
        .i_load_req(ctrl[`BCP_CTRL_LOAD_REQ]),
        .i_rise(swreg[4*p]),
        .i_fall(swreg[4*p+1]),
        .i_third(swreg[4*p+2]),
        .i_len(swreg[4*p+3]),
        .o_count(),
        .o_a(raw_a[p]),
        .o_b(raw_b[p])
      );
    end
  endgenerate

  // high and low side drive come from pair 0
  assign hs = raw_a[0];
  assign ls = raw_b[0];

  // ==========================================================
  // output selection
  always @* begin
    next_wave[0] = raw_a[0];
    next_wave[1] = raw_b[0] ^ ctrl[`BCP_CTRL_INV1];
    next_wave[2] = raw_a[1];
    next_wave[3] = raw_b[1] ^ ctrl[`BCP_CTRL_INV3];
    next_wave[4] = raw_a[2] ^ ctrl[`BCP_CTRL_POL_INV];
    if (!ctrl[`BCP_CTRL_BRIDGE]) begin
      next_wave[3:0] = next_wave[3:0] ^ {4{ctrl[`BCP_CTRL_POL_INV]}};
    end else if (ctrl[`BCP_CTRL_HS_OFF]) begin
      next_wave[3:0] = 4'h5;
    end else if (!ctrl[`BCP_CTRL_BR_OUT_EN]) begin
      next_wave[3:0] = 4'hF;
    end else if (!ctrl[`BCP_CTRL_POL_INV]) begin
      if (ctrl[`BCP_CTRL_PHASE_SIDE])
        next_wave[3:0] = {2'h0, ls, hs};
      else
        next_wave[3:0] = {ls, hs, 2'h0};
    end else begin
      if (ctrl[`BCP_CTRL_PHASE_SIDE])
        next_wave[3:0] = {ls, hs, 2'h3};
      else
        next_wave[3:0] = {2'h3, ls, hs};
    end
  end

  // registered pin drive
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_WAVE <= 5'h05;
      O_PIN_PWM_SEL <= 5'h1F;
    end else begin
      O_WAVE <= next_wave;
      O_PIN_PWM_SEL <= 5'h1F;
    end
  end
endmodule // bcp_pwm

// ==== dv/bcp_pwm_chk.sv ====
`timescale 1ns/100ps
// ==========================================================
// port checks for the waveform unit
module bcp_pwm_chk #(
  parameter CW = 16
) (
  input wire I_CLK,
  input wire I_RESET,
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [31:0] I_WB_ADR,
  input wire [3:0] I_WB_SEL,
  input wire [31:0] I_WB_DAT,
  input wire [31:0] O_WB_DAT,
  input wire O_WB_ACK,
  input wire I_TRIP_N,
  input wire I_SYNC_N,
  input wire [4:0] O_WAVE,
  input wire [4:0] O_PIN_PWM_SEL,
  input wire O_IRQ
);
  default clocking dc @(posedge I_CLK);
  endclocking
  default disable iff (I_RESET);
  // request taken on this edge
  wire take = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  wire clr_take = take && I_WB_WE && I_WB_ADR == 32'hFFFF0FB8;
  sequence s_quiet;
    I_TRIP_N [*4];
  endsequence
  sequence s_rd_hole;
    take && !I_WB_WE && I_WB_ADR == 32'hFFFF0FAC;
  endsequence
  // bus answer timing, pin select and interrupt
  a_ack_follows: assert property (take |=> O_WB_ACK) else $error("ack missing");
  a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack too long");
  a_upper_zero: assert property (O_WB_ACK |-> O_WB_DAT[31:16] == 16'h0000)
    else $error("upper data not zero");
  a_hole_zero: assert property (s_rd_hole |=> O_WB_DAT == 32'h00000000)
    else $error("hole read not zero");
  a_pin_default: assert property (O_PIN_PWM_SEL == 5'h1F) else $error("pin select");
  a_irq_holds: assert property (O_IRQ && !clr_take |=> O_IRQ) else $error("irq lost");
  a_irq_clears: assert property (s_quiet ##0 clr_take |=> !O_IRQ) else $error("irq kept");
  a_irq_cause: assert property ($rose(O_IRQ) |->
    !$past(I_TRIP_N, 3) || !$past(I_TRIP_N, 4) || !$past(I_TRIP_N, 5))
    else $error("irq without trip");
endmodule // bcp_pwm_chk

bind bcp_pwm bcp_pwm_chk #(.CW(CW)) chk_i (.I_CLK(I_CLK), .I_RESET(I_RESET),
  .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
  .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
  .I_TRIP_N(I_TRIP_N), .I_SYNC_N(I_SYNC_N), .O_WAVE(O_WAVE),
  .O_PIN_PWM_SEL(O_PIN_PWM_SEL), .O_IRQ(O_IRQ));

// ==== dv/bcp_stage.sv ====
`timescale 1ns/100ps
// ==========================================================
// power stage model: flags a fault on its pulled-up trip line
module bcp_stage (
  input wire i_clk,
  input wire i_fault,
  output logic o_trip_n = 1'b1
);
  // trip line low while a fault is flagged, released high after
  always @(posedge i_clk) begin
    o_trip_n <= ~i_fault;
  end
endmodule // bcp_stage

// ==== dv/tb.sv ====
`timescale 1ns/100ps
// ==========================================================
// self-checking bench for the waveform unit
module tb;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, sync_n = 1, fault = 0;
  logic trip_n, ack, irq;
  logic [31:0] adr = 0, dat = 0, rdat;
  logic [3:0] sel = 0;
  logic [4:0] wave, pinsel;
  logic [15:0] q;
  int err_total = 0, num_checks = 0;
  logic [7:0] offs [11] = '{8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'h98, 8'h9C, 8'hA0,
    8'hA4, 8'hA8, 8'hB0};
  logic [15:0] vals [11] = '{1, 4, 3, 7, 1, 4, 3, 7, 1, 4, 7};
  logic [15:0] bc [7] = '{16'h0002, 16'h0012, 16'h0212, 16'h0202, 16'h0206, 16'h0222,
    16'h0226};
  logic [4:0] bw [7] = '{5'h0F, 5'h05, 5'h05, 5'h00, 5'h00, 5'h1C, 5'h13};
  int hp [5] = '{3, 4, 3, 4, 3}, hb [5] = '{0, 0, 3, 4, 3};
  // clock
  always #2 clk = ~clk;
  bcp_pwm uut (.I_CLK(clk), .I_RESET(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_TRIP_N(trip_n), .I_SYNC_N(sync_n), .O_WAVE(wave), .O_PIN_PWM_SEL(pinsel),
    .O_IRQ(irq));
  bcp_stage stage (.i_clk(clk), .i_fault(fault), .o_trip_n(trip_n));
  // comparison and verdict
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one classic bus cycle, read data left in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, sel} <= {2'b11, w, 4'h3};
    adr <= {24'hFFFF0F, a};
    dat <= {16'h0000, d};
    // ack and read data are taken at the rising edge that samples ack high
    do begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        err_total++;
        close_out();
      end
    end while (ack !== 1'b1);
    q = rdat[15:0];
    {cyc, stb, we, sel} <= 7'h00;
  endtask
  task automatic t_reset;
    wb(0, 8'h80, 0);
    chk("ctrl", q, 16'h0012);
    chk("wave", wave, 5'h05);
    chk("pinsel", pinsel, 5'h1F);
    for (int i = 0; i < 11; i++) begin
      wb(0, offs[i], 0);
      chk("cmp reset", q, 0);
    end
  endtask
  // register access, hole and write-only clear
  task automatic t_regs;
    for (int i = 0; i < 11; i++) wb(1, offs[i], 16'hC3A0 ^ 16'(i));
    for (int i = 0; i < 11; i++) begin
      wb(0, offs[i], 0);
      chk("cmp rw", q, 16'hC3A0 ^ 16'(i));
    end
    wb(1, 8'hAC, 16'hFFFF);
    wb(0, 8'hAC, 0);
    chk("hole", q, 0);
    wb(0, 8'hB8, 0);
    chk("clr read", q, 0);
  endtask
  task automatic t_bridge;
    for (int i = 0; i < 7; i++) begin
      wb(1, 8'h80, bc[i]);
      repeat (3) @(negedge clk);
      chk("bridge", wave, bw[i]);
    end
  endtask
  // duty per output, two dividers, bridge drive
  task automatic t_wave;
    int h [5];
    for (int i = 0; i < 11; i++) wb(1, offs[i], vals[i]);
    for (int c = 0; c < 3; c++) begin
      wb(1, 8'h80, (c == 2) ? 16'h020B : (16'h0009 | 16'(c << 6)));
      repeat (64) @(negedge clk);
      h = '{0, 0, 0, 0, 0};
      for (int k = 0; k < (64 << (c & 1)); k++) begin
        @(negedge clk);
        for (int b = 0; b < 5; b++) h[b] += wave[b];
      end
      for (int b = 0; b < 5; b++)
        chk("duty", h[b], ((c == 2) ? hb[b] : hp[b]) * (8 << (c & 1)));
    end
  endtask
  task automatic t_trip;
    int n;
    n = 0;
    wb(1, 8'h80, 16'h0409);
    @(posedge clk);
    fault <= 1;
    while (irq !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 20) begin
        err_total++;
        close_out();
      end
    end
    @(posedge clk);
    fault <= 0;
    wb(0, 8'h80, 0);
    chk("ctrl trip", q, 16'h0408);
    chk("wave stop", wave, 5'h00);
    repeat (10) @(negedge clk);
    chk("irq hold", irq, 1);
    wb(0, 8'hB4, 0);
    chk("status set", q, 16'h0007);
    wb(1, 8'hB8, 16'h5A3C);
    repeat (2) @(negedge clk);
    chk("irq clr", irq, 0);
    wb(0, 8'hB4, 0);
    chk("status clr", q, 16'h0006);
  endtask
  // sync pulses restart timers only when enabled
  task automatic t_sync(input logic [15:0] c, input logic e);
    int hi;
    hi = 0;
    wb(1, 8'hA4, 16'h0020);
    wb(1, 8'hA8, 16'h0030);
    wb(1, 8'hB0, 16'h003F);
    wb(1, 8'h80, c);
    wb(1, 8'h80, c | 16'h0001);
    repeat (6) begin
      @(posedge clk);
      sync_n <= 0;
      repeat (2) @(posedge clk);
      sync_n <= 1;
      repeat (37) @(negedge clk) hi += wave[4];
    end
    chk("sync", hi != 0, e);
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    t_reset();
    t_regs();
    t_bridge();
    t_wave();
    t_trip();
    t_sync(16'h0008, 1);
    t_sync(16'h4008, 0);
    close_out();
  end
endmodule // tb
